// ---- common/mf_pkg.sv ----
package mf_pkg;

  // Geometry of the coding array and the output array.
  localparam int ROW_N          = 24;
  localparam int COL_N          = 240;
  localparam int ROWS_PER_SB    = 8;
  localparam int SB_N           = 3;
  localparam int BLK_COLS       = 30;
  localparam int BLK_N          = 8;
  localparam int INFO_R5        = 235;
  localparam int INFO_R14       = 226;
  localparam int PAR_R5         = 5;
  localparam int PAR_R14        = 14;
  localparam int PAR_MAX        = 14;
  localparam int IL_SB_STRIDE   = 1920;
  localparam int IL_COL_STRIDE  = 8;
  localparam int IL_N           = 5760;
  localparam int OUT_N          = 6144;
  localparam int ADDR_W         = 13;

  // Line frame layout.
  localparam logic [4:0] G0_SLOT       = 5'h00;
  localparam logic [4:0] G1_SLOT       = 5'h10;
  localparam logic [4:0] MGMT_SLOT     = 5'h01;
  localparam int         FRAME_PAR_BIT = 5;
  localparam logic [7:0] ALIGN_BYTE    = 8'h1B;
  localparam logic [7:0] ALIGN_MASK    = 8'h7F;
  localparam logic [7:0] NOALIGN_BYTE  = 8'h02;
  localparam int         NOALIGN_BIT   = 1;
  localparam logic [1:0] SYNC_LOSS     = 2'h3;
  localparam logic [1:0] MF_RUN        = 2'h2;

  // Management byte fields.
  localparam logic [7:0] CNT_MASK      = 8'h1F;
  localparam logic [7:0] ERR_BITS_MASK = 8'hE0;
  localparam logic [1:0] SB_LAST       = 2'h2;
  localparam logic [2:0] BLK_LAST      = 3'h7;
  localparam logic [4:0] POS_FIRST     = 5'h00;
  localparam logic [1:0] LVL_0         = 2'h0;
  localparam logic [1:0] LVL_1         = 2'h1;
  localparam logic [1:0] LVL_2         = 2'h2;
  localparam logic [1:0] LVL_3         = 2'h3;
  localparam int         DFS_W         = 16;

  // Galois field.
  localparam logic [7:0] GF_POLY   = 8'h87;
  localparam logic [7:0] GF_ALPHA  = 8'h02;
  localparam int         GEN_ROOT0 = 120;

  // Wishbone register map.
  localparam int         WB_AW       = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SIGNAL  = 8'h04;
  localparam logic [7:0] REG_ERRMAP  = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0C;
  localparam int         CTRL_TXEN   = 0;
  localparam int         CTRL_VAR    = 1;
  localparam int         SIG_G1_LSB  = 0;
  localparam int         SIG_SUP_LSB = 8;
  localparam int         ST_FLOCK    = 0;
  localparam int         ST_MFLOCK   = 1;
  localparam int         ST_DECODE   = 2;
  localparam int         ST_ERR_LSB  = 4;
  localparam int         ST_TXBUSY   = 8;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [15:0] SIGNAL_RST = 16'h0000;
  localparam logic [31:0] ERRMAP_RST = 32'hE0A0_4000;

  typedef enum logic [1:0] {K_MGMT, K_SUPV, K_PAY, K_PAR} kind_e;
  typedef enum logic [1:0] {TX_IDLE, TX_FILL, TX_SEND} tx_state_e;
  typedef enum logic [1:0] {FS_HUNT, FS_CHK1, FS_CHK2, FS_LOCK} fs_state_e;

  // Multiplies two field elements modulo the field polynomial.
  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] s;
    p = 8'h00;
    s = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ s;
      s = s[7] ? ({s[6:0], 1'b0} ^ GF_POLY) : {s[6:0], 1'b0};
    end
    return p;
  endfunction

  // Low coefficients of the product of (x + alpha^i) over r roots.
  function automatic logic [PAR_MAX-1:0][7:0] gen_poly(input int r);
    logic [PAR_MAX:0][7:0] g;
    logic [7:0]            root;
    g    = '0;
    g[0] = 8'h01;
    root = 8'h01;
    for (int n = 0; n < GEN_ROOT0; n++) root = gf_mul(root, GF_ALPHA);
    for (int n = 0; n < r; n++) begin
      for (int k = PAR_MAX; k > 0; k--) g[k] = g[k-1] ^ gf_mul(g[k], root);
      g[0] = gf_mul(g[0], root);
      root = gf_mul(root, GF_ALPHA);
    end
    return g[PAR_MAX-1:0];
  endfunction

  localparam logic [PAR_MAX-1:0][7:0] GEN_R5  = gen_poly(PAR_R5);
  localparam logic [PAR_MAX-1:0][7:0] GEN_R14 = gen_poly(PAR_R14);

endpackage

// ---- rtl/g704_multiframe_fec_sync.sv ----
// Function
// R1: Output array bytes go out from element zero upward to the last.
// R2: Each byte goes out lowest-numbered bit first.
// R3: Code symbols are bytes in the field of x^8+x^7+x^2+x+1.
// R4: Generator is the product of (x - alpha^i), i from 120 to 119+R.
// R5: Higher-capacity variant uses 5 parity bytes per 240-byte row.
// R6: Lower-capacity variant uses 14 parity bytes per 240-byte row.
// R7: Frame lock needs align, then non-align with bit 1 set, then align.
// R8: Frame lock drops after three wrong align bytes in a row.
// R9: Multiframe alignment uses bits 0 to 4 of the management byte.
// R10: Multiframe lock when block count steps twice in eight-frame strides.
// R11: Decoding starts only at the next complete multiframe.
// R12: Multiframe lock drops after three consecutive count sequence failures.
// R13: The error level is spread over bits 5 to 7 of the management byte.
// R14: Recovered error level goes into the outgoing logical frame field.
// R15: Stream CRC failure or corrected symbols raise the level to 1.
// R16: Header CRC failure or uncorrected symbols raise the level to 2.
// R17: Loss of synchronisation raises the level to 3.
// R18: The received error level is never lowered.
// R19: With a data field size of zero the error level is ignored.
// R20: Element (i,j) goes to 1920*(i div 8) + 8*j + (i mod 8).
// R21: Interleaved bytes fill the output around align and signal slots.
// R22: Management and supervision bytes sit in every thirtieth column.
// R23: Parity makes each 240-column row one complete codeword.
// R24: Encoding is systematic with parity in the final columns.
// R25: The error level spread is held in a writable lookup table.
module g704_multiframe_fec_sync (
  // Clock and reset.
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  // Wishbone slave.
  input  wire logic [mf_pkg::WB_AW-1:0]  wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic                      wb_we_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // Transmit payload.
  input  wire logic [7:0]                pay_data_i,
  input  wire logic                      pay_valid_i,
  output logic                           pay_ready_o,
  input  wire logic [1:0]                tx_err_level_i,
  // Transmit line.
  output logic                           tx_bit_o,
  output logic                           tx_bit_valid_o,
  output logic                           tx_mf_start_o,
  // Receive line bytes.
  input  wire logic [7:0]                rx_byte_i,
  input  wire logic                      rx_byte_valid_i,
  // Receive quality events.
  input  wire logic                      crc_stream_fail_i,
  input  wire logic                      rs_corrected_i,
  input  wire logic                      eoh_crc_fail_i,
  input  wire logic                      rs_uncorrected_i,
  input  wire logic [mf_pkg::DFS_W-1:0]  data_field_size_i,
  // Receive status.
  output logic                           frame_lock_o,
  output logic                           mf_lock_o,
  output logic                           decode_active_o,
  output logic                           rx_mf_start_o,
  output logic      [1:0]                rx_err_level_o
);
  import mf_pkg::*;

  function automatic kind_e pos_kind(input logic [2:0] r8,
                                     input logic [4:0] c30,
                                     input logic [7:0] col,
                                     input logic [7:0] info);
    if (col >= info) return K_PAR;
    if (c30 == 5'h00 && r8 == 3'h0) return K_MGMT;
    if (c30 == 5'h00 && r8 == 3'h1) return K_SUPV;
    return K_PAY;
  endfunction

  function automatic logic [4:0] next_pos(input logic [4:0] pos);
    if (pos[2:0] != BLK_LAST) return pos + 5'h01;
    if (pos[4:3] == SB_LAST) return POS_FIRST;
    return {pos[4:3] + 2'h1, 3'h0};
  endfunction

  function automatic logic [7:0] map_entry(input logic [31:0] map,
                                           input logic [1:0]  lvl);
    return map[{lvl, 3'h0} +: 8];
  endfunction

  function automatic logic [1:0] max2(input logic [1:0] a,
                                      input logic [1:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // Register file.
  logic        ack_r;
  logic [31:0] dat_r;
  logic [1:0]  ctrl_r;
  logic [15:0] sig_r;
  logic [31:0] map_r;
  logic [31:0] stat_w;
  logic [31:0] rd_mux;
  tx_state_e   tx_state_r;
  fs_state_e   fs_state_r;
  logic        mf_lock_r;
  logic        decode_r;
  logic [1:0]  err_r;

  wire        wb_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wb_wr   = wb_req & wb_we_i;
  wire [31:0] ctrl_w  = lane_merge({30'h0, ctrl_r}, wb_dat_i, wb_sel_i);
  wire [31:0] sig_w   = lane_merge({16'h0, sig_r}, wb_dat_i, wb_sel_i);
  wire [31:0] map_w   = lane_merge(map_r, wb_dat_i, wb_sel_i);

  always_comb begin
    stat_w                     = 32'h0;
    stat_w[ST_FLOCK]           = (fs_state_r == FS_LOCK);
    stat_w[ST_MFLOCK]          = mf_lock_r;
    stat_w[ST_DECODE]          = decode_r;
    stat_w[ST_ERR_LSB +: 2]    = err_r;
    stat_w[ST_TXBUSY]          = (tx_state_r != TX_IDLE);
  end

  assign rd_mux = (wb_adr_i == REG_CTRL)   ? {30'h0, ctrl_r} :
                  (wb_adr_i == REG_SIGNAL) ? {16'h0, sig_r}  :
                  (wb_adr_i == REG_ERRMAP) ? map_r           :
                  (wb_adr_i == REG_STATUS) ? stat_w          : 32'h0;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_r  <= 1'b0;
      dat_r  <= 32'h0;
      ctrl_r <= CTRL_RST;
      sig_r  <= SIGNAL_RST;
      map_r  <= ERRMAP_RST;
    end else begin
      ack_r <= wb_req;
      dat_r <= wb_req ? rd_mux : 32'h0;
      if (wb_wr && wb_adr_i == REG_CTRL) ctrl_r <= ctrl_w[1:0];
      if (wb_wr && wb_adr_i == REG_SIGNAL) sig_r <= sig_w[15:0];
      if (wb_wr && wb_adr_i == REG_ERRMAP) map_r <= map_w; // [R25]
    end
  end

  // Transmit: fill the interleaved store row by row.
  logic                  var_r;
  logic [1:0]            tx_lvl_r;
  logic [1:0]            sb_r, sb_nxt;
  logic [2:0]            r8_r, r8_nxt;
  logic [7:0]            col_r, col_nxt;
  logic [4:0]            c30_r, c30_nxt;
  logic [2:0]            blk_r, blk_nxt;
  logic                  ready_r;
  tx_state_e             tx_state_nxt;
  logic [PAR_MAX-1:0][7:0] par_r;
  wire  [PAR_MAX-1:0][7:0] par_nxt;
  logic [7:0]            wdat_w;
  logic [7:0]            rd_data;

  wire [7:0] info_cols = var_r ? 8'(INFO_R14) : 8'(INFO_R5); // [R5] [R6]
  wire kind_e kind_w   = pos_kind(r8_r, c30_r, col_r, info_cols); // [R22]
  wire       row_end   = (col_r == 8'(COL_N - 1));
  wire       fill_last = row_end && r8_r == 3'(ROWS_PER_SB - 1) &&
                         sb_r == 2'(SB_N - 1);
  wire       fill_go   = (tx_state_r == TX_FILL) &&
                         (kind_w != K_PAY || (pay_valid_i && ready_r));
  wire [7:0] par_top   = var_r ? par_r[PAR_R14-1] : par_r[PAR_R5-1];
  wire [PAR_MAX-1:0][7:0] gsel = var_r ? GEN_R14 : GEN_R5; // [R4]
  wire [7:0] fb        = (kind_w == K_PAR) ? 8'h00 : (wdat_w ^ par_top);
  wire [7:0] mgmt_byte = (map_entry(map_r, tx_lvl_r) & ERR_BITS_MASK) |
                         ({3'h0, sb_r, blk_r} & CNT_MASK); // [R13] [R9]
  wire [ADDR_W-1:0] waddr = ADDR_W'(IL_SB_STRIDE * sb_r) +
                            ADDR_W'(IL_COL_STRIDE * col_r) +
                            ADDR_W'(r8_r); // [R20]

  always_comb begin
    case (kind_w)
      K_MGMT:  wdat_w = mgmt_byte;
      K_SUPV:  wdat_w = sig_r[SIG_SUP_LSB +: 8];
      K_PAY:   wdat_w = pay_data_i;
      K_PAR:   wdat_w = par_top; // [R24]
      default: wdat_w = 8'h00;
    endcase
  end

  // Systematic encoder; parity leaves highest degree first. [R3] [R23]
  genvar k;
  generate
    for (k = 0; k < PAR_MAX; k++) begin : g_par
      if (k == 0) begin : g_lo
        assign par_nxt[k] = gf_mul(fb, gsel[k]);
      end else begin : g_hi
        assign par_nxt[k] = par_r[k-1] ^ gf_mul(fb, gsel[k]);
      end
    end
  endgenerate

  always_comb begin
    sb_nxt  = sb_r;
    r8_nxt  = r8_r;
    col_nxt = col_r;
    c30_nxt = c30_r;
    blk_nxt = blk_r;
    if (fill_go && fill_last) begin
      sb_nxt  = 2'h0;
      r8_nxt  = 3'h0;
      col_nxt = 8'h00;
      c30_nxt = 5'h00;
      blk_nxt = 3'h0;
    end else if (fill_go && row_end) begin
      col_nxt = 8'h00;
      c30_nxt = 5'h00;
      blk_nxt = 3'h0;
      r8_nxt  = r8_r + 3'h1;
      sb_nxt  = (r8_r == 3'(ROWS_PER_SB - 1)) ? sb_r + 2'h1 : sb_r;
    end else if (fill_go) begin
      col_nxt = col_r + 8'h01;
      c30_nxt = (c30_r == 5'(BLK_COLS - 1)) ? 5'h00 : c30_r + 5'h01;
      blk_nxt = (c30_r == 5'(BLK_COLS - 1)) ? blk_r + 3'h1 : blk_r;
    end
  end

  // Transmit: read the store out around the line slots.
  logic [ADDR_W-1:0] q_r, prd_r;
  logic [2:0]        bit_r;
  logic [7:0]        sh_r;
  logic              txb_r, txv_r, txmf_r;

  wire       g0_slot   = (q_r[4:0] == G0_SLOT);
  wire       g1_slot   = (q_r[4:0] == G1_SLOT);
  wire [7:0] g0_byte   = q_r[FRAME_PAR_BIT] ? NOALIGN_BYTE : ALIGN_BYTE;
  wire [7:0] byte_sel  = g0_slot ? g0_byte :
                         g1_slot ? sig_r[SIG_G1_LSB +: 8] : rd_data; // [R21]
  wire       byte_done = (tx_state_r == TX_SEND) && (bit_r == 3'h7);
  wire       send_last = byte_done && (q_r == ADDR_W'(OUT_N - 1));

  always_comb begin
    case (tx_state_r)
      TX_IDLE: tx_state_nxt = ctrl_r[CTRL_TXEN] ? TX_FILL : TX_IDLE;
      TX_FILL: tx_state_nxt = (fill_go && fill_last) ? TX_SEND : TX_FILL;
      TX_SEND: tx_state_nxt = !send_last ? TX_SEND :
                              ctrl_r[CTRL_TXEN] ? TX_FILL : TX_IDLE;
      default: tx_state_nxt = TX_IDLE;
    endcase
  end

  wire ready_nxt = (tx_state_nxt == TX_FILL) &&
                   (pos_kind(r8_nxt, c30_nxt, col_nxt, info_cols) == K_PAY);
  wire fill_enter = (tx_state_nxt == TX_FILL) && (tx_state_r != TX_FILL);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_state_r <= TX_IDLE;
      {sb_r, r8_r, col_r, c30_r, blk_r} <= '0;
      ready_r    <= 1'b0;
      var_r      <= 1'b0;
      tx_lvl_r   <= LVL_0;
    end else begin
      tx_state_r <= tx_state_nxt;
      {sb_r, r8_r, col_r, c30_r, blk_r} <=
        {sb_nxt, r8_nxt, col_nxt, c30_nxt, blk_nxt};
      ready_r    <= ready_nxt;
      if (fill_enter) begin
        var_r    <= ctrl_r[CTRL_VAR];
        tx_lvl_r <= tx_err_level_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || tx_state_r != TX_FILL || (fill_go && row_end)) begin
      par_r <= '0;
    end else if (fill_go) begin
      par_r <= par_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || tx_state_r != TX_SEND) begin
      {q_r, prd_r, bit_r, sh_r} <= '0;
      {txb_r, txv_r, txmf_r}    <= '0;
    end else begin
      bit_r  <= bit_r + 3'h1;
      txv_r  <= 1'b1;
      txmf_r <= (bit_r == 3'h0) && (q_r == '0); // [R1]
      txb_r  <= (bit_r == 3'h0) ? byte_sel[0] : sh_r[0]; // [R2]
      sh_r   <= (bit_r == 3'h0) ? (byte_sel >> 1) : (sh_r >> 1);
      if (bit_r == 3'h0 && !g0_slot && !g1_slot) prd_r <= prd_r + 1'b1;
      if (byte_done) q_r <= q_r + 1'b1; // [R1]
    end
  end

  mf_store u_store (
    .ref_clk_i (ref_clk_i),
    .wr_en_i   (fill_go),
    .wr_addr_i (waddr),
    .wr_data_i (wdat_w),
    .rd_addr_i (prd_r),
    .rd_data_o (rd_data)
  );

  // Receive: line frame alignment.
  logic [4:0] slot_r;
  logic       fpar_r;
  logic [1:0] fs_miss_r;
  logic [2:0] fr8_r;
  fs_state_e  fs_state_nxt;

  wire is_align = ((rx_byte_i ^ ALIGN_BYTE) & ALIGN_MASK) == 8'h00;
  wire at_slot0 = rx_byte_valid_i && (slot_r == G0_SLOT);
  wire fs_fail  = at_slot0 && !fpar_r && !is_align;

  always_comb begin
    fs_state_nxt = fs_state_r;
    case (fs_state_r)
      FS_HUNT: if (rx_byte_valid_i && is_align) fs_state_nxt = FS_CHK1;
      FS_CHK1: if (at_slot0) begin
        fs_state_nxt = (!is_align && rx_byte_i[NOALIGN_BIT]) ?
                       FS_CHK2 : FS_HUNT; // [R7]
      end
      FS_CHK2: if (at_slot0) fs_state_nxt = is_align ? FS_LOCK : FS_HUNT;
      FS_LOCK: if (fs_fail && fs_miss_r == SYNC_LOSS - 2'h1) begin
        fs_state_nxt = FS_HUNT; // [R8]
      end
      default: fs_state_nxt = FS_HUNT;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fs_state_r <= FS_HUNT;
      {slot_r, fpar_r, fs_miss_r, fr8_r} <= '0;
    end else begin
      fs_state_r <= fs_state_nxt;
      if (fs_state_r == FS_HUNT) slot_r <= MGMT_SLOT;
      else if (rx_byte_valid_i) slot_r <= slot_r + 5'h01;
      if (fs_state_r != FS_LOCK) begin
        fpar_r    <= 1'b1;
        fs_miss_r <= 2'h0;
        fr8_r     <= 3'h0;
      end else if (at_slot0) begin
        fpar_r    <= ~fpar_r;
        fr8_r     <= fr8_r + 3'h1;
        if (!fpar_r) fs_miss_r <= is_align ? 2'h0 : fs_miss_r + 2'h1;
      end
    end
  end

  // Receive: multiframe alignment from the management byte.
  logic [BLK_N-1:0][2:0] mf_prev_r;
  logic [BLK_N-1:0][1:0] mf_run_r;
  logic [2:0]            mf_ph_r;
  logic [4:0]            exp_r;
  logic [1:0]            mf_miss_r;
  logic [1:0]            rec_r, raise_r;
  logic                  mfs_r;

  wire       m_strobe = rx_byte_valid_i && fs_state_r == FS_LOCK &&
                        slot_r == MGMT_SLOT;
  wire [4:0] rx_pos   = rx_byte_i[4:0] & CNT_MASK[4:0]; // [R9]
  wire       step_ok  = rx_pos[2:0] == mf_prev_r[fr8_r] + 3'h1;
  wire       mf_acq   = m_strobe && !mf_lock_r && step_ok &&
                        mf_run_r[fr8_r] == MF_RUN - 2'h1; // [R10]
  wire       mf_hit   = m_strobe && mf_lock_r && fr8_r == mf_ph_r;
  wire       mf_bad   = mf_hit && rx_pos != exp_r;
  wire       mf_drop  = fs_state_r != FS_LOCK ||
                        (mf_bad && mf_miss_r == SYNC_LOSS - 2'h1); // [R12]
  wire [1:0] ev_lvl   = !mf_lock_r ? LVL_3 :                       // [R17]
                        (eoh_crc_fail_i || rs_uncorrected_i) ? LVL_2 :
                        (crc_stream_fail_i || rs_corrected_i) ? LVL_1 :
                        LVL_0; // [R15] [R16]

  function automatic logic [1:0] lut_match(input logic [7:0]  b,
                                           input logic [31:0] map);
    logic [1:0] lvl;
    lvl = LVL_2;
    for (int n = 0; n < 4; n++) begin
      if (((b ^ map_entry(map, 2'(n))) & ERR_BITS_MASK) == 8'h00) begin
        lvl = 2'(n);
      end
    end
    return lvl;
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || fs_state_r != FS_LOCK || mf_lock_r) begin
      mf_prev_r <= '0;
      mf_run_r  <= '0;
    end else if (m_strobe) begin
      mf_prev_r[fr8_r] <= rx_pos[2:0];
      mf_run_r[fr8_r]  <= !step_ok ? 2'h0 :
                          (mf_run_r[fr8_r] == MF_RUN) ? MF_RUN :
                          mf_run_r[fr8_r] + 2'h1; // [R10]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      {mf_lock_r, decode_r, mfs_r, mf_ph_r, exp_r, mf_miss_r} <= '0;
    end else if (mf_drop) begin
      {mf_lock_r, decode_r, mfs_r, mf_miss_r} <= '0;
    end else begin
      mfs_r <= mf_hit && exp_r == POS_FIRST;
      if (mf_acq) begin
        mf_lock_r <= 1'b1;
        mf_ph_r   <= fr8_r;
        exp_r     <= next_pos(rx_pos);
        mf_miss_r <= 2'h0;
      end else if (mf_hit) begin
        exp_r     <= next_pos(exp_r);
        mf_miss_r <= mf_bad ? mf_miss_r + 2'h1 : 2'h0;
        if (exp_r == POS_FIRST) decode_r <= 1'b1; // [R11]
      end
    end
  end

  // Receive: error level carried into the outgoing logical frame.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rec_r   <= LVL_0;
      raise_r <= LVL_3;
      err_r   <= LVL_0;
    end else begin
      if (mf_hit) rec_r <= lut_match(rx_byte_i, map_r); // [R14] [R13]
      raise_r <= mf_hit ? ev_lvl : max2(raise_r, ev_lvl);
      err_r   <= (data_field_size_i == '0) ? LVL_0 :      // [R19]
                 max2(rec_r, raise_r); // [R18]
    end
  end

  assign wb_dat_o        = dat_r;
  assign wb_ack_o        = ack_r;
  assign pay_ready_o     = ready_r;
  assign tx_bit_o        = txb_r;
  assign tx_bit_valid_o  = txv_r;
  assign tx_mf_start_o   = txmf_r;
  assign frame_lock_o    = (fs_state_r == FS_LOCK);
  assign mf_lock_o       = mf_lock_r;
  assign decode_active_o = decode_r;
  assign rx_mf_start_o   = mfs_r;
  assign rx_err_level_o  = err_r;

endmodule

// ---- rtl/mf_store.sv ----
module mf_store (
  // Clock.
  input  wire logic                      ref_clk_i,
  // Write port.
  input  wire logic                      wr_en_i,
  input  wire logic [mf_pkg::ADDR_W-1:0] wr_addr_i,
  input  wire logic [7:0]                wr_data_i,
  // Read port.
  input  wire logic [mf_pkg::ADDR_W-1:0] rd_addr_i,
  output logic      [7:0]                rd_data_o
);
  import mf_pkg::*;

  logic [7:0] mem [IL_N];

  // Holds the interleaved array, indexed by interleave position.
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

// ---- verification/mf_checker.sv ----
module mf_checker (
  // Watched ports.
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        tx_bit_o,
  input wire logic        tx_bit_valid_o,
  input wire logic        tx_mf_start_o,
  input wire logic [15:0] data_field_size_i,
  input wire logic        frame_lock_o,
  input wire logic        mf_lock_o,
  input wire logic        decode_active_o,
  input wire logic        rx_mf_start_o,
  input wire logic [1:0]  rx_err_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mf_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence bits_s;
    tx_bit_o [*2] ##1 !tx_bit_o ##1 tx_bit_o [*2] ##1 !tx_bit_o [*3];
  endsequence
  AST_FIRST: assert property ($rose(tx_bit_valid_o) |-> tx_mf_start_o)
    else $error("send began late");
  AST_BITS: assert property (tx_mf_start_o |-> bits_s)
    else $error("align bits wrong");
  AST_MFUP: assert property ($rose(mf_lock_o) |-> frame_lock_o)
    else $error("mf lock without frame lock");
  AST_MFDROP: assert property (!frame_lock_o [*3] |-> !mf_lock_o)
    else $error("mf lock kept");
  AST_EARLY: assert property ($rose(mf_lock_o) |-> !decode_active_o)
    else $error("decode with lock");
  AST_DEC: assert property ($rose(decode_active_o) |-> rx_mf_start_o)
    else $error("decode off start");
  AST_LVL3: assert property (
    (!mf_lock_o && data_field_size_i != 16'h0000) [*2] |=>
    rx_err_level_o == LVL_3) else $error("level not raised");
  AST_DFS0: assert property (
    data_field_size_i == 16'h0000 |=> rx_err_level_o == LVL_0)
    else $error("level not ignored");
endmodule
bind g704_multiframe_fec_sync mf_checker chk (.*);

// ---- verification/mf_tx_sink.sv ----
module mf_tx_sink (
  // Serial line and collected bytes.
  input  wire logic       ref_clk_i,
  input  wire logic       bit_i,
  input  wire logic       valid_i,
  input  wire logic       start_i,
  output logic      [7:0] byte_o [64],
  output int              nbit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial nbit_o = 0;
  always @(posedge ref_clk_i) begin
    if (start_i) nbit_o = 0;
    if (valid_i && nbit_o < 512) begin
      byte_o[nbit_o / 8][nbit_o % 8] = bit_i;
      nbit_o++;
    end
  end
endmodule

// ---- verification/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mf_pkg::*;
  logic        ref_clk_i, rst_n_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic        pay_valid_i, pay_ready_o, tx_bit_o, tx_bit_valid_o;
  logic        tx_mf_start_o, rx_byte_valid_i, crc_stream_fail_i;
  logic        rs_corrected_i, eoh_crc_fail_i, rs_uncorrected_i;
  logic        frame_lock_o, mf_lock_o, decode_active_o, rx_mf_start_o;
  logic [1:0]  tx_err_level_i, rx_err_level_o;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, pay_data_i, rx_byte_i, sb [64];
  logic [7:0]  qe [8] = '{ALIGN_BYTE, 8'h40, 8'hA5, 8'hC6, 8'h00, 8'h5A,
                          8'h5E, NOALIGN_BYTE};
  logic [15:0] data_field_size_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          qi [8] = '{0, 1, 2, 3, 9, 16, 17, 32};
  int          failures = 0, n_checks = 0, nbit, cyc_n = 0;
  g704_multiframe_fec_sync uut (.*);
  mf_tx_sink sink (.ref_clk_i, .bit_i(tx_bit_o), .valid_i(tx_bit_valid_o),
                   .start_i(tx_mf_start_o), .byte_o(sb), .nbit_o(nbit));
  initial begin
    ref_clk_i = 1'h0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc_n++;
    if (pay_valid_i && pay_ready_o) pay_data_i <= pay_data_i + 8'h01;
    if (cyc_n > 40000) end_of_test();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge ref_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <=
      {2'h3, w, s, a, d};
    do @(posedge ref_clk_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic frames(input int lo, input int hi, input logic bad);
    for (int k = lo; k <= hi; k++)
      for (int s = 0; s < 32; s++) begin
        @(posedge ref_clk_i);
        rx_byte_valid_i <= 1'h1;
        rx_byte_i <= s == 0 ? (bad ? 8'h00 : k % 2 ? NOALIGN_BYTE : ALIGN_BYTE)
          : 8'(s == 1 && k % 8 == 0 ? 8'h40 + k % 192 / 64 * 8 + k / 8 % 8 : 0);
      end
    @(posedge ref_clk_i);
    rx_byte_valid_i <= 1'h0;
    #1;
  endtask
  task automatic end_of_test();
    failures += int'(cyc_n > 40000);
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {rst_n_i, wb_we_i, wb_cyc_i, wb_stb_i, pay_valid_i, rx_byte_valid_i,
     crc_stream_fail_i, rs_corrected_i, eoh_crc_fail_i, rs_uncorrected_i,
     wb_sel_i, wb_adr_i, pay_data_i, rx_byte_i, wb_dat_i} = '0;
    tx_err_level_i = LVL_1;
    data_field_size_i = 16'h0010;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    wb(REG_ERRMAP, 1'h0, 32'h0, 4'h0);
    chk(rd, ERRMAP_RST);
    wb(REG_SIGNAL, 1'h1, 32'h0000A5FF, 4'h2);
    wb(REG_SIGNAL, 1'h1, 32'h0000FF5A, 4'h1);
    wb(8'h10, 1'h1, 32'hFFFFFFFF, 4'hF);
    wb(REG_SIGNAL, 1'h0, 32'h0, 4'h0);
    chk(rd, 32'h0000A55A);
    wb(8'h10, 1'h0, 32'h0, 4'h0);
    chk(rd, 32'h0);
    $display("registers done");
    frames(0, 1, 1'h0);
    chk(frame_lock_o, 1'h0);
    frames(2, 24, 1'h0);
    chk(frame_lock_o, 1'h1);
    chk(mf_lock_o, 1'h1);
    frames(25, 191, 1'h0);
    chk(decode_active_o, 1'h0);
    frames(192, 193, 1'h0);
    chk(decode_active_o, 1'h1);
    chk(rx_err_level_o, LVL_1);
    rs_uncorrected_i <= 1'h1;
    frames(194, 195, 1'h0);
    chk(rx_err_level_o, LVL_2);
    rs_uncorrected_i <= 1'h0;
    data_field_size_i <= 16'h0000;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(rx_err_level_o, LVL_0);
    data_field_size_i <= 16'h0010;
    frames(196, 201, 1'h1);
    chk(frame_lock_o, 1'h0);
    chk(rx_err_level_o, LVL_3);
    $display("receive done");
    pay_valid_i <= 1'h1;
    wb(REG_CTRL, 1'h1, 32'h1, 4'hF);
    wait (nbit >= 512);
    foreach (qi[n]) chk(sb[qi[n]], qe[n]);
    $display("transmit done");
    end_of_test();
  end
endmodule
